// ---- core/dss_div.sv ----
// Free-running divider with synchronous realign
module dss_div #(
    parameter int LEN = 16 // Divide ratio
) (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset, active low
    input wire logic realign, // Restart at zero
    output logic tick // Pulse at wrap
);
    localparam int W = $clog2(LEN);
    localparam logic [W-1:0] LAST = W'(LEN - 1);
    logic [W-1:0] cnt_ff; // Phase counter
    // Count, restart on realign
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else if (realign || cnt_ff == LAST) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= cnt_ff + W'(1);
        end
    end
    assign tick = (cnt_ff == LAST) & ~realign;
endmodule : dss_div

// ---- core/dss_edge.sv ----
// Rising edge detector on a synchronous input
module dss_edge (
    input wire logic clk, // Clock
    input wire logic rst_n, // Async reset, active low
    input wire logic din, // Level in
    output logic rise // One-cycle pulse on rise
);
    logic prev_ff; // Last sample
    // Hold previous level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= din;
        end
    end
    assign rise = din & ~prev_ff;
endmodule : dss_edge

// ---- core/dss_pkg.sv ----
// Operation
// - Align pulse rising edge resets feedback dividers
// - Single mode: read reset resampled from write reset
// - Single mode with PLL: no strobe read alignment
// - Pointer and formatter sources from regs 32, 31
// - Divider source reg32 bit0, enable reg0 bit2
// - Reg24 bit 11 enables feedback divider alignment
// - Dual mode: divider alignment may stay enabled
// - Transmission only when gate pin or gate bit set
// - Strobe sampled on conversion clock, internal in PLL mode
package dss_pkg;
    // Word indices; byte address is index times four
    localparam logic [7:0] REG0_IDX = 8'h00; // Main control
    localparam logic [7:0] REG24_IDX = 8'h18; // Feedback divider control
    localparam logic [7:0] REG27_IDX = 8'h1b; // Fuse control
    localparam logic [7:0] REG31_IDX = 8'h1f; // Formatter source
    localparam logic [7:0] REG32_IDX = 8'h20; // Pointer sources
    localparam logic [7:0] STAT_IDX = 8'h21; // Own status register
    // Field positions
    localparam int CLKDIV_ENA_BIT = 2;
    localparam int TXGATE_BIT = 0; // In reg 31, own choice of spot
    localparam int PLL_ENA_BIT = 0; // In reg 24
    localparam int DUAL_MODE_BIT = 1; // In reg 24
    localparam int NDIV_ALIGN_BIT = 11;
    localparam int FUSE_SLEEP_BIT = 11;
    localparam int FMT_SEL_LSB = 2;
    localparam int RDSEL_LSB = 8;
    localparam int WRSEL_LSB = 12;
    localparam int CLKDIV_SEL_BIT = 0;
    // Source codes for 4-bit pointer selects
    localparam logic [3:0] SRC_OFF = 4'h0;
    localparam logic [3:0] SRC_FRAME = 4'h1;
    localparam logic [3:0] SRC_ALIGN = 4'h2;
    localparam logic [3:0] SRC_STROBE = 4'h4;
    // Reset values
    localparam logic [15:0] REG_RST = 16'h0000;
    // Divider lengths and idle sample
    localparam int NDIV_LEN = 16;
    localparam int CLKDIV_LEN = 8;
    localparam logic [15:0] IDLE_SAMPLE = 16'h0000;
    // Reset pulse least width, host side
    localparam int RESET_MIN_NS = 25;
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : dss_pkg

// ---- core/dss_top.sv ----
// Start-up and alignment sequencer with AHB-Lite register slave
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
module dss_top (
    input wire logic hclk, // Bus and conversion clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Byte address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write flag
    input wire logic [2:0] hsize, // Transfer size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response, always OKAY
    input wire logic frame_strobe_pair, // Frame input, synchronous
    input wire logic align_pulse_pair, // Sync pulse input
    input wire logic output_strobe_reference, // External strobe
    input wire logic tx_gate_pin, // Transmit gate pin
    input wire logic [15:0] sample_in, // Incoming sample
    output logic [15:0] sample_out, // Conversion output
    output logic wr_ptr_reset, // FIFO write pointer reset pulse
    output logic rd_ptr_reset, // FIFO read pointer reset pulse
    output logic fmt_reset, // Formatter reset pulse
    output logic clkdiv_realign, // Clock divider realign pulse
    output logic ndiv_realign, // Feedback divider reset pulse
    output logic fuse_sleep, // Fuse power-down level
    output logic tx_active // Transmission running
);
    // Registers
    logic [15:0] reg0_ff, reg24_ff, reg27_ff, reg31_ff, reg32_ff;
    logic [7:0] addr_ff; // Latched word index
    logic wr_ff; // Write data phase pending
    logic [15:0] hrdata_ff; // Read data
    logic wrp_ff, rdp_ff, fmt_ff, cdiv_ff, ndiv_ff; // Pulse outputs
    logic wr_sync1_ff, wr_sync2_ff; // Read-pointer handoff chain
    logic fuse_ff, txa_ff; // Level outputs
    logic [15:0] out_ff; // Sample output
    logic [7:0] seen_ff; // Sticky event history for status
    // Bus decode
    wire take = hsel & hready & htrans[1]; // Address phase taken
    wire wr_take = take & hwrite;
    wire [7:0] idx = haddr[9:2];
    // Register fields
    wire pll_en = reg24_ff[dss_pkg::PLL_ENA_BIT];
    wire dual = reg24_ff[dss_pkg::DUAL_MODE_BIT];
    wire ndiv_ena = reg24_ff[dss_pkg::NDIV_ALIGN_BIT];
    wire cdiv_ena = reg0_ff[dss_pkg::CLKDIV_ENA_BIT];
    wire [3:0] wr_sel = reg32_ff[dss_pkg::WRSEL_LSB +: 4];
    wire [3:0] rd_sel = reg32_ff[dss_pkg::RDSEL_LSB +: 4];
    wire [1:0] fmt_sel = reg31_ff[dss_pkg::FMT_SEL_LSB +: 2];
    wire cdiv_sel = reg32_ff[dss_pkg::CLKDIV_SEL_BIT];
    wire sif_gate = reg31_ff[dss_pkg::TXGATE_BIT];
    // Edge events
    wire frame_rise, align_rise, ext_strobe_rise, nd_tick;
    dss_edge u_fr (
        .clk(hclk),
        .rst_n(hresetn),
        .din(frame_strobe_pair),
        .rise(frame_rise)
    );
    dss_edge u_al (
        .clk(hclk),
        .rst_n(hresetn),
        .din(align_pulse_pair),
        .rise(align_rise)
    );
    // External strobe sampled on conversion clock
    dss_edge u_os (
        .clk(hclk),
        .rst_n(hresetn),
        .din(output_strobe_reference),
        .rise(ext_strobe_rise)
    );
    wire nd_reset = ndiv_ena & align_rise;
    dss_div #(
        .LEN(dss_pkg::NDIV_LEN)
    ) u_ndiv (
        .clk(hclk),
        .rst_n(hresetn),
        .realign(nd_reset),
        .tick(nd_tick)
    );
    // Strobe source: internal divider in PLL mode
    wire strobe = pll_en ? nd_tick : ext_strobe_rise;
    // Source select for 4-bit fields
    function automatic logic pick4(input logic [3:0] sel, input logic fr,
                                   input logic al, input logic st);
        pick4 = (sel[0] & fr) | (sel[1] & al) | (sel[2] & st);
    endfunction : pick4
    wire wr_ev = pick4(wr_sel, frame_rise, align_rise, 1'b0);
    // Single mode resamples write reset; single with PLL never uses strobe
    wire rd_dual = dual & pick4(rd_sel, frame_rise, align_rise, strobe);
    wire rd_single = ~dual & wr_sync2_ff;
    wire rd_ev = rd_dual | rd_single;
    // Formatter: 00 frame, 01 align, 1x disabled
    wire fmt_ev = ~fmt_sel[1] & (fmt_sel[0] ? align_rise : frame_rise);
    // Divider: bit0 selects strobe (1) or frame/align (0)
    wire cdiv_src = cdiv_sel ? strobe : (frame_rise | align_rise);
    wire cdiv_ev = cdiv_ena & cdiv_src;
    wire gate = tx_gate_pin | sif_gate;
    wire [15:0] rd_word = (idx == dss_pkg::REG0_IDX) ? reg0_ff :
                          (idx == dss_pkg::REG24_IDX) ? reg24_ff :
                          (idx == dss_pkg::REG27_IDX) ? reg27_ff :
                          (idx == dss_pkg::REG31_IDX) ? reg31_ff :
                          (idx == dss_pkg::REG32_IDX) ? reg32_ff :
                          (idx == dss_pkg::STAT_IDX) ? {7'h00, txa_ff, seen_ff} :
                          16'h0000;
    wire [7:0] nxt_seen = {3'h0, nd_reset, cdiv_ev, fmt_ev, rd_ev, wr_ev}; // Sticky set terms
    // Address phase capture; writes land one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff <= 8'h00;
            wr_ff <= 1'b0;
            hrdata_ff <= 16'h0000;
        end else begin
            wr_ff <= wr_take;
            if (take) begin
                addr_ff <= idx;
            end
            if (take && !hwrite) begin
                hrdata_ff <= rd_word;
            end
        end
    end
    // Register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reg0_ff <= dss_pkg::REG_RST;
            reg24_ff <= dss_pkg::REG_RST;
            reg27_ff <= dss_pkg::REG_RST;
            reg31_ff <= dss_pkg::REG_RST;
            reg32_ff <= dss_pkg::REG_RST;
        end else if (wr_ff) begin
            case (addr_ff)
                dss_pkg::REG0_IDX: reg0_ff <= hwdata[15:0];
                dss_pkg::REG24_IDX: reg24_ff <= hwdata[15:0];
                dss_pkg::REG27_IDX: reg27_ff <= hwdata[15:0];
                dss_pkg::REG31_IDX: reg31_ff <= hwdata[15:0];
                dss_pkg::REG32_IDX: reg32_ff <= hwdata[15:0];
                default: reg0_ff <= reg0_ff; // Unmapped write ignored
            endcase
        end
    end
    // Write-reset handoff chain into read domain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_sync1_ff <= 1'b0;
            wr_sync2_ff <= 1'b0;
        end else begin
            wr_sync1_ff <= wr_ev;
            wr_sync2_ff <= wr_sync1_ff;
        end
    end
    // Registered pulse and level outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wrp_ff <= 1'b0;
            rdp_ff <= 1'b0;
            fmt_ff <= 1'b0;
            cdiv_ff <= 1'b0;
            ndiv_ff <= 1'b0;
            fuse_ff <= 1'b0;
            txa_ff <= 1'b0;
            seen_ff <= 8'h00;
        end else begin
            wrp_ff <= wr_ev;
            rdp_ff <= rd_ev;
            fmt_ff <= fmt_ev;
            cdiv_ff <= cdiv_ev;
            ndiv_ff <= nd_reset;
            fuse_ff <= reg27_ff[dss_pkg::FUSE_SLEEP_BIT];
            txa_ff <= gate;
            seen_ff <= seen_ff | nxt_seen;
        end
    end
    // Sample path, idle while gated off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_ff <= dss_pkg::IDLE_SAMPLE;
        end else if (gate) begin
            out_ff <= sample_in;
        end else begin
            out_ff <= dss_pkg::IDLE_SAMPLE;
        end
    end
    assign hrdata = {16'h0000, hrdata_ff};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign sample_out = out_ff;
    assign wr_ptr_reset = wrp_ff;
    assign rd_ptr_reset = rdp_ff;
    assign fmt_reset = fmt_ff;
    assign clkdiv_realign = cdiv_ff;
    assign ndiv_realign = ndiv_ff;
    assign fuse_sleep = fuse_ff;
    assign tx_active = txa_ff;
endmodule : dss_top

// ---- test/dss_source.sv ----
// Data source and clock distributor on the far side
module dss_source (
    input wire logic clk, // Conversion clock
    output logic frame_strobe_pair, // Frame line
    output logic align_pulse_pair, // Align line
    output logic output_strobe_reference, // Periodic strobe
    output logic [15:0] sample_in // Sample word
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ph_ff; // Strobe phase
    initial begin
        {frame_strobe_pair, align_pulse_pair, output_strobe_reference} = 3'h0;
        sample_in = 16'h0000;
        ph_ff = 4'h0;
    end
    // Samples change every cycle so stale data never passes for fresh
    always @(posedge clk) begin
        sample_in <= sample_in + 16'h0001;
        ph_ff <= ph_ff + 4'h1;
        output_strobe_reference <= (ph_ff == 4'hf);
    end
    // One rising edge, held two cycles, so no periodic sync in single mode
    task automatic pulse(input logic frame);
        @(posedge clk);
        if (frame) frame_strobe_pair <= 1'b1;
        else align_pulse_pair <= 1'b1;
        repeat (2) @(posedge clk);
        frame_strobe_pair <= 1'b0;
        align_pulse_pair <= 1'b0;
    endtask : pulse
endmodule : dss_source

// ---- test/dss_top_assertions.sv ----
module dss_top_assertions (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Reset, active low
    input wire logic hsel, // Select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write flag
    input wire logic [31:0] hwdata, // Write data
    input wire logic hreadyout, // Slave ready
    input wire logic align_pulse_pair, // Align input
    input wire logic tx_gate_pin, // Gate pin
    input wire logic [15:0] sample_in, // Sample in
    input wire logic [15:0] sample_out, // Sample out
    input wire logic wr_ptr_reset, // Write reset
    input wire logic rd_ptr_reset, // Read reset
    input wire logic clkdiv_realign, // Divider realign
    input wire logic ndiv_realign, // Feedback reset
    input wire logic tx_active // Running
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic ap_w_ff; // Write address phase seen
    logic [7:0] ap_a_ff; // Its word index
    logic ndiv_en_ff; // Shadow of feedback align enable
    logic dual_ff; // Shadow of dual mode
    logic gate_ff; // Shadow of software gate
    // Shadow registers track bus writes, landing with the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_w_ff <= 1'b0;
            ap_a_ff <= 8'h00;
            ndiv_en_ff <= 1'b0;
            dual_ff <= 1'b0;
            gate_ff <= 1'b0;
        end else begin
            ap_w_ff <= hsel && hreadyout && htrans[1] && hwrite;
            ap_a_ff <= haddr[9:2];
            if (ap_w_ff && ap_a_ff == dss_pkg::REG24_IDX) begin
                ndiv_en_ff <= hwdata[11];
                dual_ff <= hwdata[1];
            end
            if (ap_w_ff && ap_a_ff == dss_pkg::REG31_IDX) begin
                gate_ff <= hwdata[0];
            end
        end
    end
    sequence s_align_edge;
        $rose(align_pulse_pair);
    endsequence
    property p_ndiv_fire;
        s_align_edge and ndiv_en_ff |=> ndiv_realign;
    endproperty
    a_ndiv_fire: assert property (p_ndiv_fire) else $error("no feedback reset");
    property p_ndiv_cause;
        ndiv_realign |-> $past(align_pulse_pair) && !$past(align_pulse_pair, 2);
    endproperty
    a_ndiv_cause: assert property (p_ndiv_cause) else $error("stray feedback reset");
    property p_ndiv_width;
        $rose(ndiv_realign) |=> !ndiv_realign;
    endproperty
    a_ndiv_width: assert property (p_ndiv_width) else $error("long feedback reset");
    property p_cdiv_width;
        $rose(clkdiv_realign) |=> !clkdiv_realign;
    endproperty
    a_cdiv_width: assert property (p_cdiv_width) else $error("long divider realign");
    property p_rd_follow;
        wr_ptr_reset && !dual_ff |-> ##2 rd_ptr_reset;
    endproperty
    a_rd_follow: assert property (p_rd_follow) else $error("read reset not resampled");
    property p_tx_lvl;
        tx_active == $past(tx_gate_pin | gate_ff);
    endproperty
    a_tx_lvl: assert property (p_tx_lvl) else $error("gate level wrong");
    property p_idle;
        !tx_active |-> sample_out == dss_pkg::IDLE_SAMPLE;
    endproperty
    a_idle: assert property (p_idle) else $error("output not idle");
    property p_pass;
        tx_active |-> sample_out == $past(sample_in);
    endproperty
    a_pass: assert property (p_pass) else $error("sample not passed");
    property p_ready;
        hreadyout;
    endproperty
    a_ready: assert property (p_ready) else $error("wait state inserted");
endmodule : dss_top_assertions

// ---- test/tb_top.sv ----
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin miscompares++; \
    $display("mismatch at %0t: got %h want %h", $time, (a), (b)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tx_gate_pin, tx_active, fuse_sleep;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic frame, align, strobe, wr_r, rd_r, fmt_r, cdiv_r, ndiv_r;
    logic [15:0] sample_in, sample_out;
    int miscompares, tests_run;
    int cnt [5]; // Pulse counts: wr, rd, fmt, cdiv, ndiv
    wire logic [4:0] pv = {ndiv_r, cdiv_r, fmt_r, rd_r, wr_r};
    dss_top dss_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .frame_strobe_pair(frame),
        .align_pulse_pair(align), .output_strobe_reference(strobe), .tx_gate_pin(tx_gate_pin),
        .sample_in(sample_in), .sample_out(sample_out), .wr_ptr_reset(wr_r), .rd_ptr_reset(rd_r),
        .fmt_reset(fmt_r), .clkdiv_realign(cdiv_r), .ndiv_realign(ndiv_r),
        .fuse_sleep(fuse_sleep), .tx_active(tx_active));
    dss_source dss_source_i (.clk(hclk), .frame_strobe_pair(frame), .align_pulse_pair(align),
        .output_strobe_reference(strobe), .sample_in(sample_in));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    // Count every design pulse; windows are cleared between checks
    always @(posedge hclk) begin
        for (int i = 0; i < 5; i++) cnt[i] += int'(pv[i]);
    end
    task complete_run;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    // Bounded wait for the slave's ready at a rising edge
    task wait_rdy;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                miscompares++;
                complete_run();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    // One single word transfer: address phase, then data phase
    task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task wr(input logic [7:0] idx, input logic [31:0] v);
        bus(1'b1, idx, v);
    endtask : wr
    task settle(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask : settle
    task clr;
        @(negedge hclk);
        cnt = '{default: 0};
    endtask : clr
    task t_regs;
        logic [7:0] regs [5];
        regs = '{dss_pkg::REG0_IDX, dss_pkg::REG24_IDX, dss_pkg::REG27_IDX,
            dss_pkg::REG31_IDX, dss_pkg::REG32_IDX};
        foreach (regs[i]) begin
            bus(1'b0, regs[i], 32'h0);
            `CHK(rd, 32'h0)
            wr(regs[i], 32'h1234a5a4);
            bus(1'b0, regs[i], 32'h0);
            `CHK(rd, 32'h0000a5a4)
            wr(regs[i], 32'h0);
        end
        wr(8'h40, 32'hffffffff);
        bus(1'b0, 8'h40, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(hresp, 1'b0)
        $display("test regs done");
    endtask : t_regs
    task t_link;
        wr(dss_pkg::REG0_IDX, 32'h4);
        wr(dss_pkg::REG32_IDX, 32'h1000);
        clr();
        dss_source_i.pulse(1'b1);
        settle(6);
        `CHK({cnt[4], cnt[3], cnt[2], cnt[1], cnt[0]}, {32'd0, 32'd1, 32'd1, 32'd1, 32'd1})
        wr(dss_pkg::REG32_IDX, 32'h0);
        wr(dss_pkg::REG31_IDX, 32'h8);
        wr(dss_pkg::REG0_IDX, 32'h0);
        clr();
        dss_source_i.pulse(1'b1);
        dss_source_i.pulse(1'b0);
        settle(6);
        `CHK(cnt[0] + cnt[1] + cnt[2] + cnt[3], 0)
        $display("test link done");
    endtask : t_link
    task t_ndiv;
        wr(dss_pkg::REG24_IDX, 32'h0803);
        clr();
        dss_source_i.pulse(1'b0);
        settle(4);
        `CHK(cnt[4], 1)
        wr(dss_pkg::REG24_IDX, 32'h0003);
        clr();
        dss_source_i.pulse(1'b0);
        settle(4);
        `CHK(cnt[4], 0)
        // Single mode with PLL: strobe selected for read pointer, must stay quiet
        wr(dss_pkg::REG24_IDX, 32'h0001);
        wr(dss_pkg::REG32_IDX, 32'h0400);
        clr();
        settle(33);
        `CHK(cnt[1], 0)
        // Dual mode: internal strobe realigns read pointer once per divider wrap
        wr(dss_pkg::REG24_IDX, 32'h0003);
        clr();
        settle(33);
        `CHK(cnt[1], 32 / dss_pkg::NDIV_LEN)
        $display("test feedback done");
    endtask : t_ndiv
    task t_gate;
        settle(2);
        `CHK({tx_active, sample_out}, 17'h0)
        @(posedge hclk);
        tx_gate_pin <= 1'b1;
        settle(2);
        `CHK({tx_active, sample_out}, {1'b1, sample_in - 16'h1})
        @(posedge hclk);
        tx_gate_pin <= 1'b0;
        wr(dss_pkg::REG31_IDX, 32'h1);
        settle(1);
        `CHK(tx_active, 1'b1)
        wr(dss_pkg::REG31_IDX, 32'h0);
        settle(2);
        `CHK(tx_active, 1'b0)
        wr(dss_pkg::REG27_IDX, 32'h0800);
        settle(2);
        `CHK(fuse_sleep, 1'b1)
        bus(1'b0, dss_pkg::STAT_IDX, 32'h0);
        `CHK(rd, 32'h0000001f)
        $display("test gate done");
    endtask : t_gate
    initial begin
        {hresetn, hsel, hwrite, tx_gate_pin} = 4'h0;
        {haddr, hwdata, htrans} = 66'h0;
        hsize = 3'b010;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_link();
        t_ndiv();
        t_gate();
        complete_run();
    end
endmodule : tb_top
bind dss_top dss_top_assertions dss_top_assertions_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hreadyout(hreadyout), .align_pulse_pair(align_pulse_pair), .tx_gate_pin(tx_gate_pin),
    .sample_in(sample_in), .sample_out(sample_out), .wr_ptr_reset(wr_ptr_reset),
    .rd_ptr_reset(rd_ptr_reset), .clkdiv_realign(clkdiv_realign),
    .ndiv_realign(ndiv_realign), .tx_active(tx_active));
